// ===== core/ubpt_chan_if.sv
`timescale 1ns/100ps
interface ubpt_chan_if;
   logic [31:0] addr;
   logic [31:0] mask;
   logic [31:0] value;
   logic [31:0] vmask;
   logic [7:0] cyc;
   logic [7:0] asid;
   logic data_en;
   logic hit_fetch;
   logic hit_data;
   modport owner (output addr, mask, value, vmask, cyc, asid, data_en, input hit_fetch, hit_data);
   modport matcher (input addr, mask, value, vmask, cyc, asid, data_en, output hit_fetch, hit_data);
endinterface : ubpt_chan_if

// ===== core/ubpt_chan_match.sv
`timescale 1ns/100ps
module ubpt_chan_match
   import ubpt_pkg::*;
(
   // Channel setup and result
   ubpt_chan_if.matcher chan,
   // Instruction confirmed for execution
   input wire logic fetch_valid_in,
   input wire logic [31:0] fetch_addr_in,
   input wire logic [7:0] fetch_asid_in,
   // Operand access
   input wire logic data_valid_in,
   input wire logic data_write_in,
   input wire logic [1:0] data_size_in,
   input wire logic [31:0] data_addr_in,
   input wire logic [31:0] data_value_in,
   input wire logic [7:0] data_asid_in
);

   logic [31:0] ign;
   logic [31:0] vdiff;
   logic [1:0] csz;
   logic asid_f;
   logic asid_d;
   logic rw_ok;

   // ==========================================================
   // Size window and value compare
   always_comb
   begin
      csz = chan.cyc[UBPT_CYC_SZ +: 2];
      unique case (ubpt_size_e'(data_size_in))
         UBPT_SZ_LONG: ign = UBPT_IGN_LONG;
         UBPT_SZ_WORD: ign = UBPT_IGN_WORD;
         default: ign = '0;
      endcase
      // Byte data is looked for in both halves of the low word
      unique case (ubpt_size_e'(data_size_in))
         UBPT_SZ_LONG: vdiff = (data_value_in ^ chan.value) & ~chan.vmask;
         UBPT_SZ_WORD: vdiff = {16'h0000, (data_value_in[15:0] ^ chan.value[15:0]) & ~chan.vmask[15:0]};
         default: vdiff = {16'h0000, ({2{data_value_in[7:0]}} ^ chan.value[15:0]) & ~chan.vmask[15:0]};
      endcase
      asid_f = !chan.cyc[UBPT_CYC_ASID] || (fetch_asid_in == chan.asid);
      asid_d = !chan.cyc[UBPT_CYC_ASID] || (data_asid_in == chan.asid);
      rw_ok = data_write_in ? chan.cyc[UBPT_CYC_WR] : chan.cyc[UBPT_CYC_RD];
   end

   // ==========================================================
   // Hits
   // Fetches are reads of even addresses; value setup is not looked at
   assign chan.hit_fetch = fetch_valid_in && chan.cyc[UBPT_CYC_FETCH] && chan.cyc[UBPT_CYC_RD]
      && !(chan.addr[0] && !chan.mask[0])
      && (&(~(fetch_addr_in ^ chan.addr) | chan.mask)) && asid_f;

   assign chan.hit_data = data_valid_in && chan.cyc[UBPT_CYC_DATA] && rw_ok
      && (csz == UBPT_SZ_ANY || csz == data_size_in)
      && (&(~(data_addr_in ^ chan.addr) | chan.mask | ign)) && asid_d
      && (!chan.data_en || vdiff == '0);

endmodule : ubpt_chan_match

// ===== core/ubpt_pkg.sv
package ubpt_pkg;

   // ==========================================================
   // Register map, byte addresses of 32-bit words
   localparam logic [7:0] UBPT_OFF_CTRL = 8'h00;
   localparam logic [7:0] UBPT_OFF_A_ADDR = 8'h04;
   localparam logic [7:0] UBPT_OFF_A_MASK = 8'h08;
   localparam logic [7:0] UBPT_OFF_A_CYC = 8'h0C;
   localparam logic [7:0] UBPT_OFF_A_ASID = 8'h10;
   localparam logic [7:0] UBPT_OFF_B_ADDR = 8'h14;
   localparam logic [7:0] UBPT_OFF_B_MASK = 8'h18;
   localparam logic [7:0] UBPT_OFF_B_CYC = 8'h1C;
   localparam logic [7:0] UBPT_OFF_B_ASID = 8'h20;
   localparam logic [7:0] UBPT_OFF_B_VAL = 8'h24;
   localparam logic [7:0] UBPT_OFF_B_VMASK = 8'h28;
   localparam logic [7:0] UBPT_OFF_CNT_SET = 8'h2C;
   localparam logic [7:0] UBPT_OFF_SRC = 8'h30;
   localparam logic [7:0] UBPT_OFF_DST = 8'h34;
   localparam logic [7:0] UBPT_OFF_SPC = 8'h38;
   localparam logic [7:0] UBPT_OFF_STAT = 8'h3C;

   // ==========================================================
   // Control word bit positions
   localparam int unsigned UBPT_CTL_TRACE = 0;
   localparam int unsigned UBPT_CTL_SEQ = 1;
   localparam int unsigned UBPT_CTL_A_POST = 2;
   localparam int unsigned UBPT_CTL_B_POST = 3;
   localparam int unsigned UBPT_CTL_B_DATA = 4;
   localparam int unsigned UBPT_CTL_COUNT = 5;
   localparam int unsigned UBPT_CTL_FLAG_A = 8;
   localparam int unsigned UBPT_CTL_FLAG_B = 9;
   localparam logic [9:0] UBPT_CTRL_RST = 10'h000;
   localparam logic [9:0] UBPT_CTRL_WMASK = 10'h03F;

   // ==========================================================
   // Cycle select bit positions
   localparam int unsigned UBPT_CYC_FETCH = 0;
   localparam int unsigned UBPT_CYC_DATA = 1;
   localparam int unsigned UBPT_CYC_RD = 2;
   localparam int unsigned UBPT_CYC_WR = 3;
   localparam int unsigned UBPT_CYC_SZ = 4;
   localparam int unsigned UBPT_CYC_ASID = 6;

   // ==========================================================
   // Access sizes and trace geometry
   typedef enum logic [1:0] {
      UBPT_SZ_ANY = 2'b00,
      UBPT_SZ_BYTE = 2'b01,
      UBPT_SZ_WORD = 2'b10,
      UBPT_SZ_LONG = 2'b11
   } ubpt_size_e;
   localparam logic [31:0] UBPT_IGN_LONG = 32'h0000_0003;
   localparam logic [31:0] UBPT_IGN_WORD = 32'h0000_0001;
   localparam int unsigned UBPT_TRACE_DEPTH = 8;
   localparam int unsigned UBPT_BSA_W = 28;
   localparam int unsigned UBPT_PTR_W = 4;
   localparam logic [1:0] UBPT_ODD_HALF = 2'h2;

endpackage : ubpt_pkg

// ===== core/ubpt_user_break.sv
// Chosen here: strobed register access and the placing of the registers.
`timescale 1ns/100ps
module ubpt_user_break
   import ubpt_pkg::*;
#(
   parameter int unsigned DEPTH = UBPT_TRACE_DEPTH
)
(
   // Clock and reset
   input wire logic clk_in,
   input wire logic nrst_in,
   // Register port
   input wire logic [7:0] reg_addr_in,
   input wire logic [31:0] reg_wdata_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   output logic [31:0] reg_rdata_out,
   // Instruction in execute
   input wire logic ex_valid_in,
   input wire logic [31:0] ex_pc_in,
   input wire logic [31:0] ex_next_pc_in,
   input wire logic [7:0] ex_asid_in,
   // Operand access
   input wire logic da_valid_in,
   input wire logic da_write_in,
   input wire logic [1:0] da_size_in,
   input wire logic [31:0] da_addr_in,
   input wire logic [31:0] da_value_in,
   input wire logic [7:0] da_asid_in,
   input wire logic [31:0] da_next_pc_in,
   // Branch events
   input wire logic br_valid_in,
   input wire logic br_irq_in,
   input wire logic br_delayed_in,
   input wire logic [UBPT_BSA_W-1:0] br_src_addr_in,
   input wire logic [UBPT_PTR_W-1:0] br_src_ptr_in,
   input wire logic [UBPT_BSA_W-1:0] br_dest_in,
   input wire logic br_exec_in,
   // Break request to the core
   output logic brk_req_out,
   output logic brk_pre_out,
   output logic [31:0] saved_pc_out
);

   localparam int unsigned PW = $clog2(DEPTH);

   typedef enum logic [1:0] {
      SEL_NONE = 2'b00,
      SEL_PEND = 2'b01,
      SEL_A = 2'b10,
      SEL_B = 2'b11
   } ubpt_sel_e;

   typedef struct packed {
      logic [9:0] ctrl;
      logic [31:0] a_addr;
      logic [31:0] a_mask;
      logic [7:0] a_cyc;
      logic [7:0] a_asid;
      logic [31:0] b_addr;
      logic [31:0] b_mask;
      logic [31:0] b_val;
      logic [31:0] b_vmask;
      logic [7:0] b_cyc;
      logic [7:0] b_asid;
      logic [15:0] cnt_set;
      logic [15:0] cnt;
      logic armed;
      logic pend;
      logic dly_pend;
      logic [UBPT_BSA_W-1:0] dly_dest;
      logic [31:0] saved_program_counter;
      logic [31:0] rdata;
      logic [DEPTH-1:0][31:0] src;
      logic [DEPTH-1:0][UBPT_BSA_W-1:0] dst;
      logic [DEPTH-1:0] vld;
      logic [PW-1:0] rdp;
      logic [PW-1:0] trp;
   } ubpt_state_s;

   ubpt_state_s st_ff;
   ubpt_state_s nxt_st;
   ubpt_sel_e sel;
   logic seq;
   logic a_any;
   logic b_raw;
   logic b_ok;
   logic cnt_ok;
   logic a_fire;
   logic b_fire;
   logic b_val;
   logic a_pre;
   logic b_pre;
   logic push;
   logic trace_on;
   logic [31:0] a_pc;
   logic [31:0] b_pc;
   logic [31:0] pc_sel;

   // ==========================================================
   // Channel comparators
   ubpt_chan_if ca_if ();
   ubpt_chan_if cb_if ();

   assign ca_if.addr = st_ff.a_addr;
   assign ca_if.mask = st_ff.a_mask;
   assign ca_if.value = '0;
   assign ca_if.vmask = '0;
   assign ca_if.cyc = st_ff.a_cyc;
   assign ca_if.asid = st_ff.a_asid;
   assign ca_if.data_en = 1'b0;
   assign cb_if.addr = st_ff.b_addr;
   assign cb_if.mask = st_ff.b_mask;
   assign cb_if.value = st_ff.b_val;
   assign cb_if.vmask = st_ff.b_vmask;
   assign cb_if.cyc = st_ff.b_cyc;
   assign cb_if.asid = st_ff.b_asid;
   assign cb_if.data_en = st_ff.ctrl[UBPT_CTL_B_DATA];

   ubpt_chan_match u_chan_a (
      .chan(ca_if),
      .fetch_valid_in(ex_valid_in),
      .fetch_addr_in(ex_pc_in),
      .fetch_asid_in(ex_asid_in),
      .data_valid_in(da_valid_in),
      .data_write_in(da_write_in),
      .data_size_in(da_size_in),
      .data_addr_in(da_addr_in),
      .data_value_in(da_value_in),
      .data_asid_in(da_asid_in)
   );

   ubpt_chan_match u_chan_b (
      .chan(cb_if),
      .fetch_valid_in(ex_valid_in),
      .fetch_addr_in(ex_pc_in),
      .fetch_asid_in(ex_asid_in),
      .data_valid_in(da_valid_in),
      .data_write_in(da_write_in),
      .data_size_in(da_size_in),
      .data_addr_in(da_addr_in),
      .data_value_in(da_value_in),
      .data_asid_in(da_asid_in)
   );

   // ==========================================================
   // Break decision
   always_comb
   begin
      seq = st_ff.ctrl[UBPT_CTL_SEQ];
      a_any = ca_if.hit_fetch || ca_if.hit_data;
      b_raw = cb_if.hit_fetch || cb_if.hit_data;
      // Same-cycle A and B never counts as a sequence
      b_ok = !seq || (st_ff.armed && !a_any);
      cnt_ok = !st_ff.ctrl[UBPT_CTL_COUNT] || ({1'b0, st_ff.cnt} + 17'h0_0001 >= {1'b0, st_ff.cnt_set});
      a_fire = a_any && !seq;
      b_fire = b_raw && b_ok && cnt_ok;
      b_val = b_fire && !cb_if.hit_fetch && st_ff.ctrl[UBPT_CTL_B_DATA];
      a_pre = ca_if.hit_fetch && !st_ff.ctrl[UBPT_CTL_A_POST];
      b_pre = cb_if.hit_fetch && !st_ff.ctrl[UBPT_CTL_B_POST];
      a_pc = !ca_if.hit_fetch ? da_next_pc_in : (a_pre ? ex_pc_in : ex_next_pc_in);
      b_pc = !cb_if.hit_fetch ? da_next_pc_in : (b_pre ? ex_pc_in : ex_next_pc_in);
      // Only one request reaches the core; pre-execution wins
      if (st_ff.pend && ex_valid_in)
         sel = SEL_PEND;
      else if (a_fire && a_pre)
         sel = SEL_A;
      else if (b_fire && !b_val && b_pre)
         sel = SEL_B;
      else if (a_fire)
         sel = SEL_A;
      else if (b_fire && !b_val)
         sel = SEL_B;
      else
         sel = SEL_NONE;
      unique case (sel)
         SEL_PEND: pc_sel = ex_pc_in;
         SEL_A: pc_sel = a_pc;
         SEL_B: pc_sel = b_pc;
         SEL_NONE: pc_sel = st_ff.saved_program_counter;
      endcase
   end

   assign brk_req_out = (sel != SEL_NONE);
   assign brk_pre_out = (sel == SEL_PEND) || (sel == SEL_A && a_pre) || (sel == SEL_B && b_pre);
   assign saved_pc_out = st_ff.saved_program_counter;
   assign reg_rdata_out = st_ff.rdata;

   // ==========================================================
   // Next state
   always_comb
   begin
      nxt_st = st_ff;
      nxt_st.rdata = '0;
      trace_on = reg_wr_in && reg_addr_in == UBPT_OFF_CTRL && !st_ff.ctrl[UBPT_CTL_TRACE]
         && reg_wdata_in[UBPT_CTL_TRACE];
      push = st_ff.ctrl[UBPT_CTL_TRACE] && br_valid_in;
      if (reg_wr_in)
      begin
         case (reg_addr_in)
            UBPT_OFF_CTRL: nxt_st.ctrl = (reg_wdata_in[9:0] & UBPT_CTRL_WMASK)
               | (st_ff.ctrl & reg_wdata_in[9:0] & ~UBPT_CTRL_WMASK);
            UBPT_OFF_A_ADDR: nxt_st.a_addr = reg_wdata_in;
            UBPT_OFF_A_MASK: nxt_st.a_mask = reg_wdata_in;
            UBPT_OFF_A_CYC: nxt_st.a_cyc = reg_wdata_in[7:0];
            UBPT_OFF_A_ASID: nxt_st.a_asid = reg_wdata_in[7:0];
            UBPT_OFF_B_ADDR: nxt_st.b_addr = reg_wdata_in;
            UBPT_OFF_B_MASK: nxt_st.b_mask = reg_wdata_in;
            UBPT_OFF_B_CYC: nxt_st.b_cyc = reg_wdata_in[7:0];
            UBPT_OFF_B_ASID: nxt_st.b_asid = reg_wdata_in[7:0];
            UBPT_OFF_B_VAL: nxt_st.b_val = reg_wdata_in;
            UBPT_OFF_B_VMASK: nxt_st.b_vmask = reg_wdata_in;
            UBPT_OFF_CNT_SET: nxt_st.cnt_set = reg_wdata_in[15:0];
            default: ;
         endcase
      end
      // Hardware set wins over a clearing write
      if (a_any)
         nxt_st.ctrl[UBPT_CTL_FLAG_A] = 1'b1;
      if (b_fire)
         nxt_st.ctrl[UBPT_CTL_FLAG_B] = 1'b1;
      if (!seq || b_fire)
         nxt_st.armed = 1'b0;
      if (seq && a_any)
         nxt_st.armed = 1'b1;
      if (st_ff.ctrl[UBPT_CTL_COUNT] && b_raw && b_ok)
         nxt_st.cnt = cnt_ok ? 16'h0000 : st_ff.cnt + 16'h0001;
      if (sel == SEL_PEND)
         nxt_st.pend = 1'b0;
      if (b_val)
         nxt_st.pend = 1'b1;
      if (sel != SEL_NONE)
         nxt_st.saved_program_counter = pc_sel;
      // Trace queue: entry 0 is the bottom
      if (push)
      begin
         for (int i = DEPTH - 1; i > 0; i--)
         begin
            nxt_st.src[i] = st_ff.src[i-1];
            nxt_st.dst[i] = st_ff.dst[i-1];
            nxt_st.vld[i] = st_ff.vld[i-1];
         end
         // Pointer kept raw, odd values included
         nxt_st.src[0] = {br_src_ptr_in, (br_irq_in && st_ff.dly_pend) ? st_ff.dly_dest : br_src_addr_in};
         nxt_st.dst[0] = br_dest_in;
         nxt_st.vld[0] = 1'b1;
         nxt_st.dly_pend = br_delayed_in && br_dest_in[1:0] == UBPT_ODD_HALF;
         nxt_st.dly_dest = br_dest_in;
      end
      else if (st_ff.dly_pend && ex_valid_in && ex_pc_in[UBPT_BSA_W-1:0] == st_ff.dly_dest)
         nxt_st.dly_pend = 1'b0;
      if (push && !br_exec_in && st_ff.trp != PW'(DEPTH - 1))
         nxt_st.trp = st_ff.trp + PW'(1);
      else if (br_exec_in && !push && st_ff.trp != '0)
         nxt_st.trp = st_ff.trp - PW'(1);
      if (trace_on)
      begin
         nxt_st.vld = '0;
         nxt_st.trp = '0;
      end
      if (reg_rd_in)
      begin
         case (reg_addr_in)
            UBPT_OFF_CTRL: nxt_st.rdata = {22'h00_0000, st_ff.ctrl};
            UBPT_OFF_A_ADDR: nxt_st.rdata = st_ff.a_addr;
            UBPT_OFF_A_MASK: nxt_st.rdata = st_ff.a_mask;
            UBPT_OFF_A_CYC: nxt_st.rdata = {24'h00_0000, st_ff.a_cyc};
            UBPT_OFF_A_ASID: nxt_st.rdata = {24'h00_0000, st_ff.a_asid};
            UBPT_OFF_B_ADDR: nxt_st.rdata = st_ff.b_addr;
            UBPT_OFF_B_MASK: nxt_st.rdata = st_ff.b_mask;
            UBPT_OFF_B_CYC: nxt_st.rdata = {24'h00_0000, st_ff.b_cyc};
            UBPT_OFF_B_ASID: nxt_st.rdata = {24'h00_0000, st_ff.b_asid};
            UBPT_OFF_B_VAL: nxt_st.rdata = st_ff.b_val;
            UBPT_OFF_B_VMASK: nxt_st.rdata = st_ff.b_vmask;
            UBPT_OFF_CNT_SET: nxt_st.rdata = {st_ff.cnt, st_ff.cnt_set};
            UBPT_OFF_SRC: nxt_st.rdata = st_ff.vld[st_ff.rdp] ? st_ff.src[st_ff.rdp] : '0;
            UBPT_OFF_DST:
            begin
               nxt_st.rdata = st_ff.vld[st_ff.rdp] ? {4'h0, st_ff.dst[st_ff.rdp]} : '0;
               nxt_st.rdp = st_ff.rdp - PW'(1);
            end
            UBPT_OFF_SPC: nxt_st.rdata = st_ff.saved_program_counter;
            UBPT_OFF_STAT: nxt_st.rdata = 32'({st_ff.trp, st_ff.rdp});
            default: nxt_st.rdata = '0;
         endcase
      end
   end

   // Read pointer restarts at the top so the oldest pair is read first
   always_ff @(posedge clk_in)
   begin
      if (!nrst_in)
      begin
         st_ff <= '0;
         st_ff.ctrl <= UBPT_CTRL_RST;
         st_ff.rdp <= PW'(DEPTH - 1);
      end
      else
         st_ff <= nxt_st;
   end

   // ==========================================================
   // Checks
   default clocking cb_chk @(posedge clk_in);
   endclocking
   default disable iff (!nrst_in);

   chk_pre_fetch_pc: assert property ((sel == SEL_A) && ca_if.hit_fetch && !st_ff.ctrl[UBPT_CTL_A_POST]
      |-> brk_pre_out ##1 saved_pc_out == $past(ex_pc_in)) else $error("pre break saved wrong pc");
   chk_post_fetch_pc: assert property ((sel == SEL_A) && ca_if.hit_fetch && st_ff.ctrl[UBPT_CTL_A_POST]
      |-> !brk_pre_out ##1 saved_pc_out == $past(ex_next_pc_in)) else $error("post break saved wrong pc");
   chk_data_addr_pc: assert property ((sel == SEL_B) && !cb_if.hit_fetch
      |=> saved_pc_out == $past(da_next_pc_in)) else $error("data break saved wrong pc");
   chk_value_defer: assert property (b_val && !st_ff.pend ##1 ex_valid_in
      |-> brk_req_out && brk_pre_out ##1 saved_pc_out == $past(ex_pc_in)) else $error("value break not deferred");
   chk_src_read_hold: assert property (reg_rd_in && reg_addr_in == UBPT_OFF_SRC
      |=> st_ff.rdp == $past(st_ff.rdp)) else $error("source read moved pointer");
   chk_dst_read_step: assert property (reg_rd_in && reg_addr_in == UBPT_OFF_DST
      |=> st_ff.rdp == $past(st_ff.rdp) - PW'(1)) else $error("destination read did not step");
   chk_trace_restart: assert property (trace_on
      |=> st_ff.trp == '0 && st_ff.vld == '0 && st_ff.rdp == $past(st_ff.rdp)) else $error("trace restart wrong");
   chk_trace_push: assert property (push && !br_exec_in && st_ff.trp == '0
      |=> st_ff.vld[0] && st_ff.dst[0] == $past(br_dest_in) && st_ff.trp == PW'(1)) else $error("push wrong");
   chk_flag_sticky: assert property (st_ff.ctrl[UBPT_CTL_FLAG_A] && !reg_wr_in
      |=> st_ff.ctrl[UBPT_CTL_FLAG_A]) else $error("flag lost without write");
   chk_seq_gate: assert property (seq && !st_ff.armed |-> sel != SEL_B) else $error("sequence broke early");
   chk_odd_fetch: assert property (st_ff.b_addr[0] && !st_ff.b_mask[0]
      |-> !cb_if.hit_fetch) else $error("odd fetch address matched");
   chk_write_fetch: assert property (!st_ff.a_cyc[UBPT_CYC_RD] |-> !ca_if.hit_fetch) else $error("write fetch hit");
   chk_count_hold: assert property (b_raw && b_ok && !cnt_ok
      |-> sel != SEL_B ##1 st_ff.cnt == $past(st_ff.cnt) + 16'h0001) else $error("count break early");

   cov_pre_break: cover property (brk_req_out && brk_pre_out);
   cov_seq_break: cover property (seq && sel == SEL_B);
   cov_value_break: cover property (sel == SEL_PEND);
   cov_full_queue: cover property (&st_ff.vld && reg_rd_in && reg_addr_in == UBPT_OFF_DST);

endmodule : ubpt_user_break

// ===== verification/tb_top.sv
`timescale 1ns/100ps
module tb_top;
   import ubpt_pkg::*;
   logic clk_in, nrst_in, reg_wr, reg_rd, req, pre, ex_v, da_v, br_v, br_irq, br_ex, brk_req, brk_pre, br_dly, dp;
   logic [1:0] da_sz;
   logic [7:0] reg_addr;
   logic [3:0] br_ptr;
   logic [27:0] br_src, br_dst, dd;
   logic [31:0] reg_wdata, rdata, saved_program_counter, ex_pc, ex_nxt, da_addr, a, b, d, da_val;
   logic [31:0] msrc[$], mdst[$];
   int n_errors, cmp_count, cyc_cnt, rdp;
   ubpt_core_model i_core (.clk_in(clk_in), .brk_req_in(brk_req), .brk_pre_in(brk_pre), .ex_valid_out(ex_v),
      .pc_out(ex_pc), .next_pc_out(ex_nxt), .da_valid_out(da_v), .da_size_out(da_sz), .da_addr_out(da_addr),
      .br_valid_out(br_v), .br_irq_out(br_irq), .br_exec_out(br_ex), .br_src_out(br_src), .br_ptr_out(br_ptr),
      .br_dest_out(br_dst));
   ubpt_user_break #(.DEPTH(8)) i_dut (.clk_in(clk_in), .nrst_in(nrst_in), .reg_addr_in(reg_addr),
      .reg_wdata_in(reg_wdata), .reg_wr_in(reg_wr), .reg_rd_in(reg_rd), .reg_rdata_out(rdata), .ex_valid_in(ex_v),
      .ex_pc_in(ex_pc), .ex_next_pc_in(ex_nxt), .ex_asid_in(8'h00), .da_valid_in(da_v), .da_write_in(1'b0),
      .da_size_in(da_sz), .da_addr_in(da_addr), .da_value_in(da_val), .da_asid_in(8'h00),
      .da_next_pc_in(ex_nxt), .br_valid_in(br_v), .br_irq_in(br_irq), .br_delayed_in(br_dly),
      .br_src_addr_in(br_src), .br_src_ptr_in(br_ptr), .br_dest_in(br_dst), .br_exec_in(br_ex),
      .brk_req_out(brk_req), .brk_pre_out(brk_pre), .saved_pc_out(saved_program_counter));
   // ====================
   // Checks and bus cycles
   task automatic chk(input logic [31:0] exp, input logic [31:0] act);
      cmp_count++;
      if (exp !== act)
      begin
         n_errors++;
         $display("Error at %0t: expected %h, got %h", $time, exp, act);
      end
   endtask : chk
   task automatic tally_and_finish;
      if (n_errors == 0 && cmp_count > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : tally_and_finish
   task automatic wr(input logic [7:0] ad, input logic [31:0] wd);
      @(posedge clk_in);
      reg_wr <= 1'b1;
      reg_addr <= ad;
      reg_wdata <= wd;
      @(posedge clk_in);
      reg_wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] ad, input logic [31:0] exp);
      @(posedge clk_in);
      reg_rd <= 1'b1;
      reg_addr <= ad;
      @(posedge clk_in);
      reg_rd <= 1'b0;
      #1 chk(exp, rdata);
   endtask : rd
   // Break answer {req, pre}; saved pc only checked when a break is due
   task automatic hit(input logic da, input logic [1:0] sz, input logic [31:0] pc, input logic [31:0] ad,
      input logic [1:0] er, input logic [31:0] es);
      i_core.step(~da, da, sz, pc, ad, req, pre);
      chk({30'h0, er}, {30'h0, req, pre});
      if (er[1])
         chk(es, saved_program_counter);
   endtask : hit
   // ====================
   // Clock and hang guard
   initial
   begin
      clk_in = 1'b0;
      forever #25 clk_in = ~clk_in;
   end
   always @(posedge clk_in)
   begin
      cyc_cnt++;
      if (cyc_cnt == 3000)
      begin
         n_errors++;
         tally_and_finish();
      end
   end
   // ====================
   // Main sequence
   initial
   begin
      nrst_in = 1'b0;
      {reg_wr, reg_rd, reg_addr, reg_wdata, da_val, br_dly, dp} = 76'h0;
      void'($urandom(28058));
      repeat (3) @(posedge clk_in);
      nrst_in <= 1'b1;
      for (int k = 0; k < 2; k++)
      begin
         a = $urandom & 32'hFFFF_F000;
         b = a | ($urandom & 32'h0000_0FFE);
         wr(UBPT_OFF_A_ADDR, a);
         wr(UBPT_OFF_A_MASK, 32'h0000_0FFF);
         wr(UBPT_OFF_A_CYC, 32'h0000_0005);
         wr(UBPT_OFF_CTRL, k ? 32'h0000_0004 : 32'h0000_0000);
         hit(1'b0, 2'h0, b, b, k ? 2'h2 : 2'h3, k ? b + 32'h0000_0002 : b);
      end
      wr(UBPT_OFF_A_MASK, 32'h0000_0000);
      wr(UBPT_OFF_A_ADDR, b | 32'h0000_0001);
      // Odd fetch address equal to the break address; only the even-fetch rule blocks it
      hit(1'b0, 2'h0, b | 32'h0000_0001, b, 2'h0, b);
      wr(UBPT_OFF_A_ADDR, b);
      wr(UBPT_OFF_A_CYC, 32'h0000_0009);
      hit(1'b0, 2'h0, b, b, 2'h0, b);
      // Sequential mode, first with channel A unable to match
      d = b + 32'h0000_0008;
      wr(UBPT_OFF_B_ADDR, d);
      wr(UBPT_OFF_B_CYC, 32'h0000_0005);
      wr(UBPT_OFF_CTRL, 32'h0000_0002);
      hit(1'b0, 2'h0, b, b, 2'h0, b);
      hit(1'b0, 2'h0, d, d, 2'h0, d);
      wr(UBPT_OFF_A_CYC, 32'h0000_0005);
      hit(1'b0, 2'h0, b, b, 2'h0, b);
      hit(1'b0, 2'h0, d, d, 2'h3, d);
      rd(UBPT_OFF_CTRL, 32'h0000_0302);
      wr(UBPT_OFF_CNT_SET, 32'h0000_0005);
      wr(UBPT_OFF_CTRL, 32'h0000_0020);
      for (int k = 0; k < 5; k++)
         hit(1'b0, 2'h0, d, d, k == 4 ? 2'h3 : 2'h0, d);
      // Data address break compared per access size
      wr(UBPT_OFF_CTRL, 32'h0000_0000);
      wr(UBPT_OFF_B_ADDR, {b[31:2], 2'b10});
      wr(UBPT_OFF_B_CYC, 32'h0000_0006);
      hit(1'b1, 2'h3, a, {b[31:2], 2'b00}, 2'h2, a + 32'h0000_0002);
      hit(1'b1, 2'h2, a, {b[31:2], 2'b00}, 2'h0, a);
      // Value break: wrong value first, then the match, deferred to the next instruction
      wr(UBPT_OFF_B_VAL, 32'h0000_A512);
      wr(UBPT_OFF_B_CYC, 32'h0000_0026);
      wr(UBPT_OFF_CTRL, 32'h0000_0010);
      for (int k = 0; k < 2; k++)
      begin
         da_val <= k ? 32'h0000_A512 : 32'h0000_A513;
         hit(1'b1, 2'h2, a, {b[31:2], 2'b10}, 2'h0, a);
         hit(1'b0, 2'h0, d, d, k ? 2'h3 : 2'h0, d);
      end
      // Trace: overfill the queue, then read the oldest pairs
      wr(UBPT_OFF_CTRL, 32'h0000_0001);
      for (int k = 0; k < 9; k++)
      begin
         a = $urandom;
         d = $urandom;
         // Second push: delayed branch to a 4n+2 destination, then an interrupt
         if (k == 1)
            d[2:0] = 3'b110;
         if (k == 2)
            d[0] = 1'b1;
         br_dly <= d[2];
         i_core.branch(a[27:0], a[31:28], d[27:0], d[0]);
         msrc.push_front((d[0] && dp) ? {a[31:28], dd} : a);
         mdst.push_front({4'h0, d[27:0]});
         dp = d[2] && d[1:0] == 2'b10;
         dd = d[27:0];
      end
      rdp = 7;
      repeat (2)
      begin
         rd(UBPT_OFF_SRC, msrc[rdp]);
         rd(UBPT_OFF_SRC, msrc[rdp]);
         rd(UBPT_OFF_DST, mdst[rdp]);
         rdp--;
      end
      wr(UBPT_OFF_CTRL, 32'h0000_0000);
      wr(UBPT_OFF_CTRL, 32'h0000_0001);
      rd(UBPT_OFF_SRC, 32'h0000_0000);
      rd(UBPT_OFF_DST, 32'h0000_0000);
      rd(UBPT_OFF_STAT, 32'h0000_0004);
      rd(8'hFC, 32'h0000_0000);
      tally_and_finish();
   end
endmodule : tb_top

// ===== verification/ubpt_core_model.sv
`timescale 1ns/100ps
module ubpt_core_model
(
   // Clock and break answer
   input wire logic clk_in,
   input wire logic brk_req_in,
   input wire logic brk_pre_in,
   // Execute and operand
   output logic ex_valid_out,
   output logic [31:0] pc_out,
   output logic [31:0] next_pc_out,
   output logic da_valid_out,
   output logic [1:0] da_size_out,
   output logic [31:0] da_addr_out,
   // Branch events
   output logic br_valid_out,
   output logic br_irq_out,
   output logic br_exec_out,
   output logic [27:0] br_src_out,
   output logic [3:0] br_ptr_out,
   output logic [27:0] br_dest_out
);
   // ====================
   // Idle state
   initial
   begin
      {ex_valid_out, da_valid_out, br_valid_out, br_irq_out, br_exec_out} = 5'h00;
      {pc_out, next_pc_out, da_addr_out, da_size_out} = 98'h0;
      {br_src_out, br_ptr_out, br_dest_out} = 60'h0;
   end
   // ====================
   // One instruction or operand access; released lines flip so stale values never match
   task automatic step(input logic ex, input logic da, input logic [1:0] sz, input logic [31:0] pc,
      input logic [31:0] ad, output logic rq, output logic pr);
      @(posedge clk_in);
      ex_valid_out <= ex;
      da_valid_out <= da;
      da_size_out <= sz;
      pc_out <= pc;
      next_pc_out <= pc + 32'h0000_0002;
      da_addr_out <= ad;
      #10;
      rq = brk_req_in;
      pr = brk_pre_in;
      @(posedge clk_in);
      ex_valid_out <= 1'b0;
      da_valid_out <= 1'b0;
      pc_out <= ~pc;
      da_addr_out <= ~ad;
      #1;
   endtask : step
   // ====================
   // One taken branch or interrupt
   task automatic branch(input logic [27:0] s, input logic [3:0] p, input logic [27:0] d, input logic irq);
      @(posedge clk_in);
      br_valid_out <= 1'b1;
      br_irq_out <= irq;
      br_exec_out <= d[1];
      br_src_out <= s;
      br_ptr_out <= p;
      br_dest_out <= d;
      @(posedge clk_in);
      br_valid_out <= 1'b0;
      br_exec_out <= 1'b0;
      br_src_out <= ~s;
   endtask : branch
endmodule : ubpt_core_model
